// File: core/zolc_pkg.sv
// zolc package: constants shared by the loop controller ends
package zolc_pkg;
   localparam int ZOLC_AW = 32;
   localparam logic [7:0] ZOLC_AUX_LOOP_START = 8'h02;
   localparam logic [7:0] ZOLC_AUX_LOOP_END = 8'h03;
   localparam logic [7:0] ZOLC_AUX_LOOP_COUNT = 8'h3c;
   localparam logic [31:0] ZOLC_COUNT_ONE = 32'h0000_0001;
   localparam logic [31:0] ZOLC_COUNT_ZERO = 32'h0000_0000;
   localparam logic [31:0] ZOLC_ADDR_RESET = 32'h0000_0000;
   localparam logic [31:0] ZOLC_ALIGN_MASK = 32'hffff_fffc;
   localparam logic [31:0] ZOLC_WORD_STEP = 32'h0000_0004;
   localparam logic [7:0] ZOLC_REG_CTRL = 8'h00;
   localparam logic [7:0] ZOLC_REG_PC = 8'h04;
   localparam logic [7:0] ZOLC_REG_START = 8'h08;
   localparam logic [7:0] ZOLC_REG_END = 8'h0c;
   localparam logic [7:0] ZOLC_REG_COUNT = 8'h10;
   localparam logic [7:0] ZOLC_REG_STATUS = 8'h14;
   localparam logic [7:0] ZOLC_REG_BRANCH = 8'h18;
   localparam logic [7:0] ZOLC_REG_SETUP = 8'h1c;
   localparam logic [7:0] ZOLC_REG_AUXW = 8'h20;
   localparam logic [7:0] ZOLC_REG_AUXD = 8'h24;
   localparam logic [7:0] ZOLC_REG_STEP = 8'h28;
   typedef enum logic {ZOLC_VAR_NEXT_FETCH_PC, ZOLC_VAR_CUR_PC} zolc_variant_t;
endpackage

// File: core/zolc_if.sv
// zolc interface: fetch/branch/aux-write link between core side and loop controller
`timescale 1ns/1ps
interface zolc_if;
   logic step;
   logic [31:0] current_pc;
   logic [31:0] seq_pc;
   logic branch_taken;
   logic [31:0] branch_target;
   logic loop_setup_instr;
   logic [31:0] setup_disp;
   logic aux_write_instr;
   logic [7:0] aux_addr;
   logic [31:0] aux_wdata;
   logic [31:0] next_fetch_pc;
   logic loop_taken;
   logic [31:0] loop_start_address;
   logic [31:0] loop_end_address;
   logic [31:0] loop_iteration_counter;
   modport ctrl (
      input step, current_pc, seq_pc, branch_taken, branch_target, loop_setup_instr,
      input setup_disp, aux_write_instr, aux_addr, aux_wdata,
      output next_fetch_pc, loop_taken, loop_start_address, loop_end_address,
      output loop_iteration_counter
   );
   modport core (
      output step, current_pc, seq_pc, branch_taken, branch_target, loop_setup_instr,
      output setup_disp, aux_write_instr, aux_addr, aux_wdata,
      input next_fetch_pc, loop_taken, loop_start_address, loop_end_address,
      input loop_iteration_counter
   );
endinterface

// File: core/zolc_end_detect.sv
// zolc end detect: variant-selected loop end match
`timescale 1ns/1ps
module zolc_end_detect
   import zolc_pkg::*;
#(
   parameter zolc_variant_t VARIANT = ZOLC_VAR_NEXT_FETCH_PC
) (
   input wire logic [31:0] current_pc,
   input wire logic [31:0] seq_pc,
   input wire logic [31:0] loop_end_address,
   output logic at_end
);
   // ---------------------------------------------
   // compare point
   // ---------------------------------------------
   always_comb begin
      if (VARIANT == ZOLC_VAR_NEXT_FETCH_PC) begin
         at_end = (seq_pc == loop_end_address);
      end else begin
         // last instruction: current pc plus one fixed-size word is the loop end
         at_end = ((current_pc + ZOLC_WORD_STEP) == loop_end_address);
      end
   end
endmodule

// File: core/zolc_ctrl.sv
// zolc controller: loop registers and next fetch pc selection
`timescale 1ns/1ps
module zolc_ctrl
   import zolc_pkg::*;
#(
   parameter zolc_variant_t VARIANT = ZOLC_VAR_NEXT_FETCH_PC
) (
   input wire logic clk_sys,
   input wire logic reset,
   zolc_if.ctrl lk
);
   logic [31:0] start_r, start_nxt;
   logic [31:0] end_r, end_nxt;
   logic [31:0] count_r, count_nxt;
   logic at_end;
   logic redirect;
   logic count_dec;

   zolc_end_detect #(.VARIANT(VARIANT)) u_det (
      .current_pc(lk.current_pc),
      .seq_pc(lk.seq_pc),
      .loop_end_address(end_r),
      .at_end(at_end)
   );

   // ---------------------------------------------
   // next_fetch_pc selection
   // ---------------------------------------------
   always_comb begin
      redirect = 1'b0;
      count_dec = 1'b0;
      if (VARIANT == ZOLC_VAR_NEXT_FETCH_PC) begin
         // counter looked at only on a match
         if (lk.step && !lk.branch_taken && at_end) begin
            count_dec = 1'b1;
            redirect = (count_r != ZOLC_COUNT_ONE);
         end
         // a taken branch leaves count as is; undefined by contract
      end else begin
         if (lk.step && at_end) begin
            count_dec = 1'b1;
            redirect = !lk.branch_taken && (count_r != ZOLC_COUNT_ZERO)
               && (count_r != ZOLC_COUNT_ONE);
         end
      end
   end

   always_comb begin
      if (lk.branch_taken) begin
         lk.next_fetch_pc = lk.branch_target;
      end else if (redirect) begin
         lk.next_fetch_pc = start_r;
      end else begin
         lk.next_fetch_pc = lk.seq_pc;
      end
      lk.loop_taken = redirect;
   end

   // ---------------------------------------------
   // loop registers
   // ---------------------------------------------
   always_comb begin
      start_nxt = start_r;
      end_nxt = end_r;
      count_nxt = count_r;
      if (count_dec) begin
         count_nxt = count_r - ZOLC_COUNT_ONE;
      end
      // explicit writes win; a late count write simply takes over
      if (lk.aux_write_instr) begin
         unique case (lk.aux_addr)
            ZOLC_AUX_LOOP_START: start_nxt = lk.aux_wdata;
            ZOLC_AUX_LOOP_END: end_nxt = lk.aux_wdata;
            ZOLC_AUX_LOOP_COUNT: count_nxt = lk.aux_wdata;
            default: ;
         endcase
      end
      if (lk.loop_setup_instr) begin
         end_nxt = (lk.current_pc & ZOLC_ALIGN_MASK) + lk.setup_disp;
         start_nxt = lk.seq_pc;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         start_r <= ZOLC_ADDR_RESET;
         end_r <= ZOLC_ADDR_RESET;
         count_r <= ZOLC_COUNT_ZERO;
      end else begin
         start_r <= start_nxt;
         end_r <= end_nxt;
         count_r <= count_nxt;
      end
   end

   // registered values, so a read near the end may lag
   assign lk.loop_start_address = start_r;
   assign lk.loop_end_address = end_r;
   assign lk.loop_iteration_counter = count_r;
endmodule

// File: core/zolc_core.sv
// zolc core end: register-driven model of the fetch/branch/aux-write side
//
// Design decisions made here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module zolc_core
   import zolc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] addr,
   input wire logic [31:0] wdata,
   input wire logic wr,
   input wire logic rd,
   output logic [31:0] rdata,
   zolc_if.core lk
);
   logic [31:0] pc_r, pc_nxt;
   logic [31:0] bt_r, bt_nxt;
   logic bt_en_r, bt_en_nxt;
   logic [31:0] disp_r, disp_nxt;
   logic [7:0] auxa_r, auxa_nxt;
   logic [31:0] auxd_r, auxd_nxt;
   logic step_p, setup_p, auxw_p;
   logic [31:0] rdata_r, rdata_nxt;

   // ---------------------------------------------
   // software strobes
   // ---------------------------------------------
   always_comb begin
      step_p = wr && (addr == ZOLC_REG_STEP);
      setup_p = wr && (addr == ZOLC_REG_SETUP);
      auxw_p = wr && (addr == ZOLC_REG_AUXW);
   end

   // software places the setup only in legal slots
   // and keeps breakpoint/sleep off the last slot
   always_comb begin
      lk.step = step_p;
      lk.current_pc = pc_r;
      lk.seq_pc = pc_r + ZOLC_WORD_STEP;
      lk.branch_taken = step_p && bt_en_r;
      lk.branch_target = bt_r;
      lk.loop_setup_instr = setup_p;
      // the strobing write carries the fresh value; the register lags one cycle
      lk.setup_disp = setup_p ? wdata : disp_r;
      lk.aux_write_instr = auxw_p;
      lk.aux_addr = auxw_p ? wdata[7:0] : auxa_r;
      lk.aux_wdata = auxd_r;
   end

   // ---------------------------------------------
   // state
   // ---------------------------------------------
   always_comb begin
      pc_nxt = pc_r;
      bt_nxt = bt_r;
      bt_en_nxt = bt_en_r;
      disp_nxt = disp_r;
      auxa_nxt = auxa_r;
      auxd_nxt = auxd_r;
      rdata_nxt = ZOLC_COUNT_ZERO;
      if (wr) begin
         unique case (addr)
            ZOLC_REG_PC: pc_nxt = wdata;
            ZOLC_REG_BRANCH: bt_nxt = wdata;
            ZOLC_REG_CTRL: bt_en_nxt = wdata[0];
            ZOLC_REG_SETUP: disp_nxt = wdata;
            ZOLC_REG_AUXD: auxd_nxt = wdata;
            ZOLC_REG_AUXW: auxa_nxt = wdata[7:0];
            default: ;
         endcase
      end
      // one step consumes a one-shot branch; pc follows the controller
      if (step_p) begin
         pc_nxt = lk.next_fetch_pc;
         bt_en_nxt = 1'b0;
      end
      if (rd) begin
         unique case (addr)
            ZOLC_REG_PC: rdata_nxt = pc_r;
            ZOLC_REG_START: rdata_nxt = lk.loop_start_address;
            ZOLC_REG_END: rdata_nxt = lk.loop_end_address;
            ZOLC_REG_COUNT: rdata_nxt = lk.loop_iteration_counter;
            ZOLC_REG_BRANCH: rdata_nxt = bt_r;
            ZOLC_REG_CTRL: rdata_nxt = {31'h0, bt_en_r};
            ZOLC_REG_STATUS: rdata_nxt = {31'h0, lk.loop_taken};
            default: rdata_nxt = ZOLC_COUNT_ZERO;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (reset) begin
         pc_r <= ZOLC_ADDR_RESET;
         bt_r <= ZOLC_ADDR_RESET;
         bt_en_r <= 1'b0;
         disp_r <= ZOLC_ADDR_RESET;
         auxa_r <= 8'h00;
         auxd_r <= ZOLC_ADDR_RESET;
         rdata_r <= ZOLC_COUNT_ZERO;
      end else begin
         pc_r <= pc_nxt;
         bt_r <= bt_nxt;
         bt_en_r <= bt_en_nxt;
         disp_r <= disp_nxt;
         auxa_r <= auxa_nxt;
         auxd_r <= auxd_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign rdata = rdata_r;
endmodule

// File: verif/zolc_checker.sv
// zolc checker: link assertions for the next_fetch_pc compare end
`timescale 1ns/1ps
module zolc_checker
   import zolc_pkg::*;
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic step,
   input wire logic [31:0] current_pc,
   input wire logic [31:0] seq_pc,
   input wire logic branch_taken,
   input wire logic [31:0] branch_target,
   input wire logic loop_setup_instr,
   input wire logic [31:0] setup_disp,
   input wire logic aux_write_instr,
   input wire logic [7:0] aux_addr,
   input wire logic [31:0] aux_wdata,
   input wire logic [31:0] next_fetch_pc,
   input wire logic loop_taken,
   input wire logic [31:0] loop_start_address,
   input wire logic [31:0] loop_end_address,
   input wire logic [31:0] loop_iteration_counter
);
   // ----------------------------------------
   // assertions
   // ----------------------------------------
   logic [31:0] setup_end_exp;
   logic at_end;
   assign setup_end_exp = (current_pc & ZOLC_ALIGN_MASK) + setup_disp;
   assign at_end = step && !branch_taken && (seq_pc == loop_end_address);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);
   redir_start_a: assert property (at_end && loop_iteration_counter != ZOLC_COUNT_ONE |->
      next_fetch_pc == loop_start_address && loop_taken) else $error("no jump to loop start");
   last_fall_a: assert property (at_end && loop_iteration_counter == ZOLC_COUNT_ONE |->
      next_fetch_pc == seq_pc && !loop_taken) else $error("last pass did not fall through");
   no_match_a: assert property (step && !branch_taken && seq_pc != loop_end_address |->
      next_fetch_pc == seq_pc) else $error("redirect without end match");
   branch_wins_a: assert property (branch_taken |-> next_fetch_pc == branch_target)
      else $error("branch target not taken");
   count_dec_a: assert property (at_end && !aux_write_instr && !loop_setup_instr |=>
      loop_iteration_counter == $past(loop_iteration_counter) - 1) else $error("no decrement");
   count_hold_a: assert property (!step && !aux_write_instr |=>
      $stable(loop_iteration_counter)) else $error("count moved while idle");
   aux_start_a: assert property (aux_write_instr && aux_addr == ZOLC_AUX_LOOP_START
      && !loop_setup_instr |=> loop_start_address == $past(aux_wdata)) else $error("start lost");
   setup_regs_a: assert property (loop_setup_instr |=> loop_end_address == $past(setup_end_exp)
      && loop_start_address == $past(seq_pc)) else $error("setup values wrong");
   cover property (at_end && loop_taken);
   cover property (step && branch_taken && seq_pc == loop_end_address);
   cover property (loop_setup_instr);
endmodule

// File: verif/test_zero_overhead_loop_ctrl.sv
// zolc testbench: both variants driven through the core register port
`timescale 1ns/1ps
module test_zero_overhead_loop_ctrl
   import zolc_pkg::*;
;
   logic clk_sys = 1'b0;
   logic reset = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wdata = 32'h0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic [31:0] rdata0;
   logic [31:0] rdata1;
   int miscompares = 0;
   int n_compared = 0;
   zolc_if lk0();
   zolc_if lk1();
   zolc_ctrl #(.VARIANT(ZOLC_VAR_NEXT_FETCH_PC)) i_zolc_ctrl (.clk_sys(clk_sys), .reset(reset), .lk(lk0));
   zolc_ctrl #(.VARIANT(ZOLC_VAR_CUR_PC)) i_zolc_ctrl_b (.clk_sys(clk_sys), .reset(reset), .lk(lk1));
   zolc_core i_zolc_core (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata0), .lk(lk0));
   zolc_core i_zolc_core_b (.clk_sys(clk_sys), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr),
      .rd(rd), .rdata(rdata1), .lk(lk1));
   zolc_checker i_zolc_checker (.clk_sys(clk_sys), .reset(reset), .step(lk0.step),
      .current_pc(lk0.current_pc), .seq_pc(lk0.seq_pc), .branch_taken(lk0.branch_taken),
      .branch_target(lk0.branch_target), .loop_setup_instr(lk0.loop_setup_instr),
      .setup_disp(lk0.setup_disp), .aux_write_instr(lk0.aux_write_instr),
      .aux_addr(lk0.aux_addr), .aux_wdata(lk0.aux_wdata), .next_fetch_pc(lk0.next_fetch_pc),
      .loop_taken(lk0.loop_taken), .loop_start_address(lk0.loop_start_address),
      .loop_end_address(lk0.loop_end_address),
      .loop_iteration_counter(lk0.loop_iteration_counter));
   // ----------------------------------------
   // bus tasks
   // ----------------------------------------
   initial begin
      forever #50 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk_sys);
      wr <= 1'b0;
   endtask
   // data stands only in the cycle after the strobe, so judge it mid-cycle
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] e0, input logic [31:0] e1);
      @(posedge clk_sys);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk_sys);
      rd <= 1'b0;
      @(negedge clk_sys);
      chk(rdata0, e0);
      chk(rdata1, e1);
   endtask
   task automatic aux(input logic [7:0] a, input logic [31:0] d);
      wr_reg(ZOLC_REG_AUXD, d);
      wr_reg(ZOLC_REG_AUXW, {24'h0, a});
   endtask
   task automatic step_at(input logic [31:0] pc);
      wr_reg(ZOLC_REG_PC, pc);
      wr_reg(ZOLC_REG_STEP, 32'h0);
   endtask
   // ----------------------------------------
   // scenarios
   // ----------------------------------------
   task automatic t_regs;
      rd_chk(ZOLC_REG_END, 32'h0, 32'h0);
      aux(ZOLC_AUX_LOOP_START, 32'h100);
      aux(ZOLC_AUX_LOOP_END, 32'h104);
      aux(8'h05, 32'h0bad);
      aux(ZOLC_AUX_LOOP_COUNT, 32'h2);
      rd_chk(ZOLC_REG_START, 32'h100, 32'h100);
      rd_chk(ZOLC_REG_END, 32'h104, 32'h104);
      rd_chk(8'hfc, 32'h0, 32'h0);
      $display("t_regs done");
   endtask
   // single-word loop at 0x100: counts 2 and 1 agree, count 0 splits the two variants
   task automatic t_iter;
      step_at(32'h0fc);
      rd_chk(ZOLC_REG_PC, 32'h100, 32'h100);
      step_at(32'h100);
      rd_chk(ZOLC_REG_PC, 32'h100, 32'h100);
      rd_chk(ZOLC_REG_COUNT, 32'h1, 32'h1);
      step_at(32'h100);
      rd_chk(ZOLC_REG_PC, 32'h104, 32'h104);
      step_at(32'h100);
      rd_chk(ZOLC_REG_PC, 32'h100, 32'h104);
      rd_chk(ZOLC_REG_COUNT, 32'hffff_ffff, 32'hffff_ffff);
      $display("t_iter done");
   endtask
   task automatic t_branch;
      aux(ZOLC_AUX_LOOP_COUNT, 32'h3);
      wr_reg(ZOLC_REG_BRANCH, 32'h200);
      wr_reg(ZOLC_REG_CTRL, 32'h1);
      step_at(32'h100);
      rd_chk(ZOLC_REG_PC, 32'h200, 32'h200);
      rd_chk(ZOLC_REG_COUNT, 32'h3, 32'h2);
      $display("t_branch done");
   endtask
   task automatic t_setup;
      wr_reg(ZOLC_REG_PC, 32'h40);
      wr_reg(ZOLC_REG_SETUP, 32'h20);
      rd_chk(ZOLC_REG_END, 32'h60, 32'h60);
      rd_chk(ZOLC_REG_START, 32'h44, 32'h44);
      $display("t_setup done");
   endtask
   task automatic summarize;
      $display("compared %0d mismatched %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_sys);
      miscompares++;
      summarize();
   end
   initial begin
      repeat (16) @(posedge clk_sys);
      reset <= 1'b0;
      t_regs();
      t_iter();
      t_branch();
      t_setup();
      summarize();
   end
endmodule
